// [include/mcu_exec_pkg.sv]
// Shared constants and carriers for the skip, table, swap and xor unit.
// Assumes one 100 MHz clock and a core that issues one instruction
// at a time.
package mcu_exec_pkg;
    localparam int MEM_AW = 6;
    localparam int ROM_AW = 11;
    localparam int ROM_W = 14;
    localparam int PAGE_AW = 8;

    // Register map of the plain bus port
    localparam logic [7:0] REG_MEM_BASE = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h40;
    localparam logic [7:0] REG_TBL_PTR = 8'h41;
    localparam logic [7:0] REG_TBL_HIGH = 8'h42;
    localparam logic [7:0] REG_STATUS = 8'h43;
    localparam int STATUS_ZERO_BIT = 0;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TBL_PTR_RST = 8'h00;
    localparam logic [7:0] TBL_HIGH_RST = 8'h00;
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;

    // Instruction lengths in machine cycles
    localparam int SKIP_CYCLES = 2;
    localparam int PLAIN_CYCLES = 1;
    localparam int TABLE_CYCLES = 2;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_SWAP,
        OP_NIBBLE_EXCHANGE_TO_WORKING,
        OP_SKIP_ON_ZERO,
        OP_LOAD_AND_SKIP_ON_ZERO,
        OP_SKIP_ON_BIT_ZERO,
        OP_TABLE_FETCH_CURRENT_PAGE,
        OP_TABLE_FETCH_LAST_PAGE,
        OP_XOR_TO_ACC,
        OP_EXCLUSIVE_OR_TO_MEMORY,
        OP_XOR_IMMEDIATE
    } exec_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DUMMY,
        ST_TABLE
    } exec_state_t;

    typedef struct packed {
        exec_op_t op;
        logic [MEM_AW-1:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] imm;
    } exec_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : mcu_exec_pkg

// [src/mcu_exec_unit.sv]
// Execution unit for nibble swap, skip-on-zero, table fetch and xor.
// Assumes the core holds i_exec stable with i_exec_valid while o_busy
// is low, and that program memory answers o_rom_addr combinationally.
// Contract
// - Swap memory nibbles in place, flags kept
// - Swapped byte to accumulator only, flags kept
// - Zero byte skips: 2 cycles, else 1
// - Copy byte to accumulator, skip if zero
// - Selected bit zero skips in 2 cycles
// - Current-page table word: low memory, high register
// - Last-page table word: low memory, high register
// - Xor into accumulator, only zero flag
// - Xor into memory byte, only zero flag
// - Xor immediate into accumulator, only zero flag
`timescale 1ns/1ps
`default_nettype none
module mcu_exec_unit #(
    parameter int MEM_AW = mcu_exec_pkg::MEM_AW,
    parameter int ROM_AW = mcu_exec_pkg::ROM_AW
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_exec_valid,
    input wire mcu_exec_pkg::exec_req_t i_exec,
    input wire logic [ROM_AW-mcu_exec_pkg::PAGE_AW-1:0] i_pc_page,
    input wire logic [mcu_exec_pkg::ROM_W-1:0] i_rom_data,
    input wire mcu_exec_pkg::reg_req_t i_reg,
    output logic o_busy,
    output logic o_done,
    output logic o_skip,
    output logic o_rom_rd,
    output logic [ROM_AW-1:0] o_rom_addr,
    output logic [7:0] o_rd_data,
    output logic [7:0] o_acc,
    output logic [7:0] o_table_high_byte,
    output logic o_zero
);
    localparam int MEM_DEPTH = 1 << MEM_AW;
    localparam int PAGE_W = ROM_AW - mcu_exec_pkg::PAGE_AW;

    typedef struct packed {
        mcu_exec_pkg::exec_state_t st;
        logic busy;
        logic done;
        logic skip;
        logic rom_rd;
        logic [ROM_AW-1:0] rom_addr;
        logic [MEM_AW-1:0] tbl_dst;
        logic [7:0] rd_data;
        logic [7:0] acc;
        logic zero;
        logic [7:0] table_pointer;
        logic [7:0] table_high_byte;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;
    logic accept;
    logic [7:0] operand;
    logic [7:0] xor_res;

    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[3:0], v[7:4]};
    endfunction : nib_swap

    function automatic logic mem_hit(input logic [7:0] a);
        mem_hit = (a >> MEM_AW) == 8'h00;
    endfunction : mem_hit

    assign accept = i_exec_valid && !st_r.busy;
    assign operand = st_r.mem[i_exec.addr];

    always_comb begin
        st_nxt = st_r;
        xor_res = 8'h00;
        st_nxt.done = 1'b0;
        st_nxt.skip = 1'b0;
        st_nxt.rom_rd = 1'b0;
        st_nxt.rd_data = 8'h00;
        // Bus read: data stands one cycle, unmapped reads give zero
        if (i_reg.rd) begin
            if (mem_hit(i_reg.addr)) begin
                st_nxt.rd_data = st_r.mem[i_reg.addr[MEM_AW-1:0]];
            end else begin
                unique case (i_reg.addr)
                    mcu_exec_pkg::REG_ACC: st_nxt.rd_data = st_r.acc;
                    mcu_exec_pkg::REG_TBL_PTR: begin
                        st_nxt.rd_data = st_r.table_pointer;
                    end
                    mcu_exec_pkg::REG_TBL_HIGH: begin
                        st_nxt.rd_data = st_r.table_high_byte;
                    end
                    mcu_exec_pkg::REG_STATUS: begin
                        st_nxt.rd_data[mcu_exec_pkg::STATUS_ZERO_BIT] =
                            st_r.zero;
                    end
                    default: st_nxt.rd_data = 8'h00;
                endcase
            end
        end
        // Bus write first, so an executing instruction wins a collision
        if (i_reg.wr) begin
            if (mem_hit(i_reg.addr)) begin
                st_nxt.mem[i_reg.addr[MEM_AW-1:0]] = i_reg.wdata;
            end else begin
                unique case (i_reg.addr)
                    mcu_exec_pkg::REG_ACC: st_nxt.acc = i_reg.wdata;
                    mcu_exec_pkg::REG_TBL_PTR: begin
                        st_nxt.table_pointer = i_reg.wdata;
                    end
                    mcu_exec_pkg::REG_TBL_HIGH: begin
                        st_nxt.table_high_byte = i_reg.wdata;
                    end
                    mcu_exec_pkg::REG_STATUS: begin
                        st_nxt.zero =
                            i_reg.wdata[mcu_exec_pkg::STATUS_ZERO_BIT];
                    end
                    default: st_nxt.zero = st_nxt.zero;
                endcase
            end
        end
        unique case (st_r.st)
            mcu_exec_pkg::ST_IDLE: begin
                if (accept) begin
                    st_nxt.done = 1'b1;
                    unique case (i_exec.op)
                        mcu_exec_pkg::OP_SWAP: begin
                            st_nxt.mem[i_exec.addr] = nib_swap(operand);
                        end
                        mcu_exec_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                            st_nxt.acc = nib_swap(operand);
                        end
                        mcu_exec_pkg::OP_SKIP_ON_ZERO: begin
                            st_nxt.skip = operand == 8'h00;
                        end
                        mcu_exec_pkg::OP_LOAD_AND_SKIP_ON_ZERO: begin
                            st_nxt.acc = operand;
                            st_nxt.skip = operand == 8'h00;
                        end
                        mcu_exec_pkg::OP_SKIP_ON_BIT_ZERO: begin
                            st_nxt.skip = !operand[i_exec.bit_sel];
                        end
                        mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE: begin
                            st_nxt.rom_rd = 1'b1;
                            st_nxt.rom_addr =
                                {i_pc_page, st_r.table_pointer};
                        end
                        mcu_exec_pkg::OP_TABLE_FETCH_LAST_PAGE: begin
                            st_nxt.rom_rd = 1'b1;
                            st_nxt.rom_addr =
                                {{PAGE_W{1'b1}}, st_r.table_pointer};
                        end
                        mcu_exec_pkg::OP_XOR_TO_ACC: begin
                            xor_res = st_r.acc ^ operand;
                            st_nxt.acc = xor_res;
                            st_nxt.zero = xor_res == 8'h00;
                        end
                        mcu_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
                            xor_res = st_r.acc ^ operand;
                            st_nxt.mem[i_exec.addr] = xor_res;
                            st_nxt.zero = xor_res == 8'h00;
                        end
                        mcu_exec_pkg::OP_XOR_IMMEDIATE: begin
                            xor_res = st_r.acc ^ i_exec.imm;
                            st_nxt.acc = xor_res;
                            st_nxt.zero = xor_res == 8'h00;
                        end
                        default: st_nxt.done = 1'b1;
                    endcase
                    // Skips and table fetches take a second cycle
                    if (st_nxt.skip) begin
                        st_nxt.done = 1'b0;
                        st_nxt.busy = 1'b1;
                        st_nxt.st = mcu_exec_pkg::ST_DUMMY;
                    end
                    if (st_nxt.rom_rd) begin
                        st_nxt.done = 1'b0;
                        st_nxt.busy = 1'b1;
                        st_nxt.tbl_dst = i_exec.addr;
                        st_nxt.st = mcu_exec_pkg::ST_TABLE;
                    end
                end
            end
            mcu_exec_pkg::ST_DUMMY: begin
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.st = mcu_exec_pkg::ST_IDLE;
            end
            mcu_exec_pkg::ST_TABLE: begin
                st_nxt.mem[st_r.tbl_dst] = i_rom_data[7:0];
                st_nxt.table_high_byte =
                    8'(i_rom_data[mcu_exec_pkg::ROM_W-1:8]);
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.st = mcu_exec_pkg::ST_IDLE;
            end
            default: st_nxt.st = mcu_exec_pkg::ST_IDLE;
        endcase
        if (!i_rst_b) begin
            st_nxt = '0;
            st_nxt.st = mcu_exec_pkg::ST_IDLE;
            st_nxt.acc = mcu_exec_pkg::ACC_RST;
            st_nxt.zero = mcu_exec_pkg::ZERO_RST;
            st_nxt.table_pointer = mcu_exec_pkg::TBL_PTR_RST;
            st_nxt.table_high_byte = mcu_exec_pkg::TBL_HIGH_RST;
            st_nxt.mem = {MEM_DEPTH{mcu_exec_pkg::MEM_RST}};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st_r <= st_nxt;
    end

    assign o_busy = st_r.busy;
    assign o_done = st_r.done;
    assign o_skip = st_r.skip;
    assign o_rom_rd = st_r.rom_rd;
    assign o_rom_addr = st_r.rom_addr;
    assign o_rd_data = st_r.rd_data;
    assign o_acc = st_r.acc;
    assign o_table_high_byte = st_r.table_high_byte;
    assign o_zero = st_r.zero;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    swap_mem_a: assert property (
        accept && i_exec.op == mcu_exec_pkg::OP_SWAP && !i_reg.wr
        |=> st_r.mem[$past(i_exec.addr)] == nib_swap($past(operand))
            && $stable(st_r.zero) && o_done)
        else $error("swap in memory wrong");

    swap_acc_a: assert property (
        accept && !i_reg.wr
        && i_exec.op == mcu_exec_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING
        |=> o_acc == nib_swap($past(operand))
            && st_r.mem == $past(st_r.mem) && $stable(o_zero))
        else $error("swap to accumulator wrong");

    skip_zero_a: assert property (
        accept && i_exec.op == mcu_exec_pkg::OP_SKIP_ON_ZERO
        |=> (o_skip && o_busy && !o_done
             ##1 o_done && !o_busy) or (!o_skip && o_done && !o_busy))
        else $error("skip on zero timing wrong");

    skip_cause_a: assert property (
        accept && !i_reg.wr && i_exec.op == mcu_exec_pkg::OP_SKIP_ON_ZERO
        |=> o_skip == ($past(operand) == 8'h00) && $stable(o_zero))
        else $error("skip on zero decision wrong");

    load_skip_a: assert property (
        accept && !i_reg.wr
        && i_exec.op == mcu_exec_pkg::OP_LOAD_AND_SKIP_ON_ZERO
        |=> o_acc == $past(operand)
            && o_skip == ($past(operand) == 8'h00))
        else $error("load and skip wrong");

    bit_skip_a: assert property (
        accept && i_exec.op == mcu_exec_pkg::OP_SKIP_ON_BIT_ZERO
        |=> o_skip == !$past(operand[i_exec.bit_sel]))
        else $error("bit skip decision wrong");

    table_cur_a: assert property (
        accept && i_exec.op == mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE
        |=> o_rom_rd && o_busy
            && o_rom_addr == {$past(i_pc_page), $past(st_r.table_pointer)}
        ##1 o_done && !o_busy)
        else $error("current page fetch wrong");

    table_last_a: assert property (
        accept && i_exec.op == mcu_exec_pkg::OP_TABLE_FETCH_LAST_PAGE
        |=> o_rom_rd
            && o_rom_addr == {{PAGE_W{1'b1}}, $past(st_r.table_pointer)})
        else $error("last page fetch wrong");

    table_store_a: assert property (
        o_rom_rd && !i_reg.wr
        |=> st_r.mem[$past(st_r.tbl_dst)] == $past(i_rom_data[7:0])
            && o_table_high_byte == 8'($past(i_rom_data[13:8])))
        else $error("table word not stored");

    xor_acc_a: assert property (
        accept && !i_reg.wr && i_exec.op == mcu_exec_pkg::OP_XOR_TO_ACC
        |=> o_acc == $past(st_r.acc ^ operand)
            && o_zero == (o_acc == 8'h00))
        else $error("xor to accumulator wrong");

    xor_mem_a: assert property (
        accept && !i_reg.wr
        && i_exec.op == mcu_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY
        |=> st_r.mem[$past(i_exec.addr)] == $past(st_r.acc ^ operand)
            && $stable(o_acc))
        else $error("xor to memory wrong");

    xor_imm_a: assert property (
        accept && !i_reg.wr && i_exec.op == mcu_exec_pkg::OP_XOR_IMMEDIATE
        |=> o_acc == $past(st_r.acc ^ i_exec.imm))
        else $error("xor immediate wrong");

    zero_flag_a: assert property (
        accept && !i_reg.wr
        && i_exec.op == mcu_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY
        |=> o_zero == ($past(st_r.acc) == $past(operand)))
        else $error("zero flag wrong");
endmodule : mcu_exec_unit
`default_nettype wire

// [testbench/rom_model.sv]
// Program memory model answering table fetches of the execution unit.
// Assumes the read address is presented together with the read pulse.
`timescale 1ns/1ps
`default_nettype none
module rom_model (
    input wire logic i_sys_clk,
    input wire logic i_rom_rd,
    input wire logic [10:0] i_rom_addr,
    output logic [13:0] o_rom_data
);
    logic [13:0] idle_r = 14'h0000;

    // Each address holds a distinct word so a wrong page shows
    function automatic logic [13:0] rom_word(input logic [10:0] a);
        return {a[10:5] ^ 6'h2b, a[7:0] ^ 8'h96};
    endfunction : rom_word

    // Outside a read the data lines change every cycle
    always_ff @(posedge i_sys_clk) begin
        idle_r <= ~idle_r ^ 14'h1555;
    end

    assign o_rom_data = i_rom_rd ? rom_word(i_rom_addr) : idle_r;
endmodule : rom_model
`default_nettype wire

// [testbench/mcu_swap_skip_table_xor_ops_tb.sv]
// Self-checking bench for the swap, skip, table and xor unit.
// Assumes the program memory model beside it and the package constants.
`timescale 1ns/1ps
`default_nettype none
module mcu_swap_skip_table_xor_ops_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic exec_valid = 1'b0;
    mcu_exec_pkg::exec_req_t exec_req = '0;
    mcu_exec_pkg::reg_req_t reg_req = '0;
    logic [2:0] pc_page = 3'h5;
    logic [13:0] rom_data;
    logic busy, done, skip, rom_rd, zero;
    logic [10:0] rom_addr;
    logic [7:0] rd_data, acc, table_high;
    int num_errors = 0;
    int num_checks = 0;
    int cyc;
    logic skipped;
    logic [10:0] seen_addr;
    logic [13:0] w;
    localparam logic [7:0] bit_pat = 8'h3c;

    initial begin
        forever #5 clk = ~clk;
    end

    mcu_exec_unit i_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_exec_valid(exec_valid), .i_exec(exec_req), .i_pc_page(pc_page),
        .i_rom_data(rom_data), .i_reg(reg_req), .o_busy(busy),
        .o_done(done), .o_skip(skip), .o_rom_rd(rom_rd),
        .o_rom_addr(rom_addr), .o_rd_data(rd_data), .o_acc(acc),
        .o_table_high_byte(table_high), .o_zero(zero));

    rom_model i_rom (.i_sys_clk(clk), .i_rom_rd(rom_rd),
        .i_rom_addr(rom_addr), .o_rom_data(rom_data));

    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
        check({8'h00, seen}, {8'h00, exp});
    endtask : chk8

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1;
        chk8(rd_data, e);
    endtask : reg_rd

    // Issues one instruction and counts cycles until completion
    task automatic run(input mcu_exec_pkg::exec_op_t op, input logic [5:0] a,
                       input logic [2:0] b, input logic [7:0] imm);
        @(posedge clk);
        exec_valid <= 1'b1;
        exec_req <= '{op: op, addr: a, bit_sel: b, imm: imm};
        @(posedge clk);
        exec_valid <= 1'b0;
        cyc = 1;
        skipped = 1'b0;
        #1;
        while (done !== 1'b1) begin
            check({15'h0000, busy}, 16'h0001);
            if (skip === 1'b1) skipped = 1'b1;
            if (rom_rd === 1'b1) seen_addr = rom_addr;
            if (cyc == 8) begin
                num_errors++;
                $display("unexpected at %0t: no completion", $time);
                end_of_test();
            end
            @(posedge clk);
            #1;
            cyc++;
        end
        check({15'h0000, busy}, 16'h0000);
    endtask : run

    task automatic cyc_chk(input logic [7:0] n, input logic s);
        chk8(cyc[7:0], n);
        chk8({7'h00, skipped}, {7'h00, s});
    endtask : cyc_chk

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reg_rd(mcu_exec_pkg::REG_ACC, 8'h00);
        reg_rd(mcu_exec_pkg::REG_TBL_PTR, 8'h00);
        reg_rd(mcu_exec_pkg::REG_TBL_HIGH, 8'h00);
        reg_rd(mcu_exec_pkg::REG_STATUS, 8'h00);
        reg_rd(8'h05, 8'h00);
        reg_rd(8'h50, 8'h00);
        reg_wr(mcu_exec_pkg::REG_STATUS, 8'h01);
        reg_wr(8'h03, 8'ha5);
        run(mcu_exec_pkg::OP_SWAP, 6'h03, 3'h0, 8'h00);
        cyc_chk(8'h01, 1'b0);
        reg_rd(8'h03, 8'h5a);
        reg_wr(8'h04, bit_pat);
        run(mcu_exec_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING, 6'h04, 3'h0, 8'h00);
        chk8(acc, 8'hc3);
        reg_rd(8'h04, 8'h3c);
        run(mcu_exec_pkg::OP_SKIP_ON_ZERO, 6'h05, 3'h0, 8'h00);
        cyc_chk(8'h02, 1'b1);
        run(mcu_exec_pkg::OP_SKIP_ON_ZERO, 6'h03, 3'h0, 8'h00);
        cyc_chk(8'h01, 1'b0);
        run(mcu_exec_pkg::OP_LOAD_AND_SKIP_ON_ZERO, 6'h05, 3'h0, 8'h00);
        cyc_chk(8'h02, 1'b1);
        chk8(acc, 8'h00);
        run(mcu_exec_pkg::OP_LOAD_AND_SKIP_ON_ZERO, 6'h04, 3'h0, 8'h00);
        cyc_chk(8'h01, 1'b0);
        chk8(acc, 8'h3c);
        for (int b = 0; b < 8; b++) begin
            run(mcu_exec_pkg::OP_SKIP_ON_BIT_ZERO, 6'h04, b[2:0], 8'h00);
            cyc_chk(bit_pat[b] ? 8'h01 : 8'h02, !bit_pat[b]);
        end
        reg_wr(mcu_exec_pkg::REG_TBL_PTR, 8'h37);
        run(mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE, 6'h06, 3'h0, 8'h00);
        w = i_rom.rom_word(11'h537);
        check({5'h00, seen_addr}, 16'h0537);
        reg_rd(8'h06, w[7:0]);
        reg_rd(mcu_exec_pkg::REG_TBL_HIGH, {2'b00, w[13:8]});
        chk8(table_high, {2'b00, w[13:8]});
        run(mcu_exec_pkg::OP_TABLE_FETCH_LAST_PAGE, 6'h07, 3'h0, 8'h00);
        w = i_rom.rom_word(11'h737);
        check({5'h00, seen_addr}, 16'h0737);
        reg_rd(8'h07, w[7:0]);
        reg_rd(mcu_exec_pkg::REG_TBL_HIGH, {2'b00, w[13:8]});
        chk8(table_high, {2'b00, w[13:8]});
        pc_page <= 3'h2;
        run(mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE, 6'h08, 3'h0, 8'h00);
        w = i_rom.rom_word(11'h237);
        check({5'h00, seen_addr}, 16'h0237);
        reg_rd(8'h08, w[7:0]);
        chk8(table_high, {2'b00, w[13:8]});
        reg_rd(mcu_exec_pkg::REG_STATUS, 8'h01);
        reg_wr(mcu_exec_pkg::REG_STATUS, 8'h00);
        reg_wr(mcu_exec_pkg::REG_ACC, 8'h3c);
        run(mcu_exec_pkg::OP_XOR_TO_ACC, 6'h03, 3'h0, 8'h00);
        cyc_chk(8'h01, 1'b0);
        check({acc, 7'h00, zero}, 16'h6600);
        reg_wr(8'h07, 8'h66);
        run(mcu_exec_pkg::OP_XOR_TO_ACC, 6'h07, 3'h0, 8'h00);
        check({acc, 7'h00, zero}, 16'h0001);
        reg_rd(8'h07, 8'h66);
        reg_wr(mcu_exec_pkg::REG_ACC, 8'h0f);
        reg_wr(8'h07, 8'hf0);
        run(mcu_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY, 6'h07, 3'h0, 8'h00);
        reg_rd(8'h07, 8'hff);
        check({acc, 7'h00, zero}, 16'h0f00);
        reg_wr(8'h07, 8'h0f);
        run(mcu_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY, 6'h07, 3'h0, 8'h00);
        reg_rd(8'h07, 8'h00);
        chk8({7'h00, zero}, 8'h01);
        run(mcu_exec_pkg::OP_XOR_IMMEDIATE, 6'h00, 3'h0, 8'h0f);
        check({acc, 7'h00, zero}, 16'h0001);
        run(mcu_exec_pkg::OP_XOR_IMMEDIATE, 6'h00, 3'h0, 8'ha0);
        check({acc, 7'h00, zero}, 16'ha000);
        // Second reset in mid-run clears accumulator, memory and high byte
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reg_rd(mcu_exec_pkg::REG_ACC, 8'h00);
        reg_rd(8'h03, 8'h00);
        chk8(table_high, 8'h00);
        end_of_test();
    end
endmodule : mcu_swap_skip_table_xor_ops_tb
`default_nettype wire
